/* File: ocf_pkg.sv */
// Package: register map, reset values and action codes for the compare force block
package ocf_pkg;

    localparam int          NUM_CH         = 8;
    localparam int          CH7            = 7;

    // Printed offsets are register indices; byte address is four times the index
    localparam logic [7:0]  IDX_FORCE      = 8'h01;
    localparam logic [7:0]  IDX_MASK       = 8'h02;
    localparam logic [7:0]  IDX_DATA       = 8'h03;
    localparam logic [7:0]  IDX_MODE       = 8'h04;
    localparam logic [7:0]  IDX_DISC       = 8'h05;
    localparam logic [7:0]  IDX_TOVSEL     = 8'h06;
    localparam logic [7:0]  IDX_ACTION_LO  = 8'h07;
    localparam logic [7:0]  IDX_ACTION_HI  = 8'h08;
    localparam logic [7:0]  IDX_FLAGS      = 8'h09;
    localparam logic [7:0]  IDX_PORT       = 8'h0A;

    localparam logic [7:0]  RST_MASK       = 8'h00;
    localparam logic [7:0]  RST_DATA       = 8'h00;
    localparam logic [7:0]  RST_REG8       = 8'h00;
    localparam logic [15:0] RST_ACTION     = 16'h0000;
    localparam logic [7:0]  FORCE_READ     = 8'h00;
    localparam logic [31:0] UNMAPPED_READ  = 32'h00000000;

    // Two-bit compare action per channel
    localparam logic [1:0]  ACT_NONE       = 2'h0;
    localparam logic [1:0]  ACT_TOGGLE     = 2'h1;
    localparam logic [1:0]  ACT_CLEAR      = 2'h2;
    localparam logic [1:0]  ACT_SET        = 2'h3;

endpackage

/* File: ocf_pin_action.sv */
// Module: one channel's compare pin action evaluator
`timescale 1ns/1ps
module ocf_pin_action (
    input  wire logic [1:0] action,
    input  wire logic       cur,
    input  wire logic       fire,
    output logic            nxt
);

    always_comb begin
        nxt = cur;
        if (fire) begin
            case (action)
                ocf_pkg::ACT_TOGGLE: nxt = ~cur;
                ocf_pkg::ACT_CLEAR:  nxt = 1'b0;
                ocf_pkg::ACT_SET:    nxt = 1'b1;
                default:             nxt = cur;
            endcase
        end
    end

endmodule

/* File: ocf_compare_force.sv */
// Module: compare force, channel 7 override and port data with an APB slave
//
// Notes on behaviour
// - Reading the compare force register always returns zero.
// - Writing one to a force bit fires that channel's compare pin action if its mode bit selects output compare.
// - Forced action drives the pin like a match but never sets the flag.
// - A channel 7 event overrides compares on channels 6 to 0.
// - Force and match together: force action wins, flag stays clear.
// - On channel 7 event, masked pins take the channel 7 data bit.
// - Data reaches a pin only in compare mode and not disconnected.
// - Channel 7 event copies masked data bits into the port data register.
// - Mode bit one selects output compare, zero selects input capture.
`timescale 1ns/1ps
module ocf_compare_force #(
    parameter int ADDR_W = 12
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [7:0]        compare_match,
    input  wire logic              counter_overflow,
    output logic [7:0]             pin_out,
    output logic [7:0]             pin_oe,
    output logic [7:0]             compare_flag
);

    ////////////////////////////////////////////////////////////////////////////
    // Register state

    logic [7:0]  ch7_compare_mask_reg,       ch7_compare_mask_next;
    logic [7:0]  ch7_compare_data_reg,       ch7_compare_data_next;
    logic [7:0]  channel_mode_select_reg,    channel_mode_select_next;
    logic [7:0]  output_disconnect_reg,      output_disconnect_next;
    logic [7:0]  overflow_toggle_select_reg, overflow_toggle_select_next;
    logic [15:0] action_reg,                 action_next;
    logic [7:0]  flag_reg,                   flag_next;
    logic [7:0]  port_reg,                   port_next;
    logic [7:0]  force_bit_reg,              force_bit_next;
    logic [31:0] prdata_reg,                 prdata_next;
    logic        pready_reg,                 pready_next;
    logic        pslverr_reg,                pslverr_next;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode

    // Word index match; a byte offset inside a word is refused
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(idx)) && (a[1:0] == 2'h0);
    endfunction

    logic        access;
    logic        wr;
    logic        known;
    logic [31:0] rd_val;

    // Taken once, in the first access cycle; the answer stands in the next one
    always_comb begin
        access = psel && penable && !pready_reg;
        // Every register sits in byte lane 0, so only that strobe enables a write
        wr     = access && pwrite && pstrb[0];
        known  = 1'b1;
        rd_val = ocf_pkg::UNMAPPED_READ;
        if (hit(paddr, ocf_pkg::IDX_FORCE)) begin
            rd_val = {24'h000000, ocf_pkg::FORCE_READ};
        end else if (hit(paddr, ocf_pkg::IDX_MASK)) begin
            rd_val = {24'h000000, ch7_compare_mask_reg};
        end else if (hit(paddr, ocf_pkg::IDX_DATA)) begin
            rd_val = {24'h000000, ch7_compare_data_reg};
        end else if (hit(paddr, ocf_pkg::IDX_MODE)) begin
            rd_val = {24'h000000, channel_mode_select_reg};
        end else if (hit(paddr, ocf_pkg::IDX_DISC)) begin
            rd_val = {24'h000000, output_disconnect_reg};
        end else if (hit(paddr, ocf_pkg::IDX_TOVSEL)) begin
            rd_val = {24'h000000, overflow_toggle_select_reg};
        end else if (hit(paddr, ocf_pkg::IDX_ACTION_LO)) begin
            rd_val = {24'h000000, action_reg[7:0]};
        end else if (hit(paddr, ocf_pkg::IDX_ACTION_HI)) begin
            rd_val = {24'h000000, action_reg[15:8]};
        end else if (hit(paddr, ocf_pkg::IDX_FLAGS)) begin
            rd_val = {24'h000000, flag_reg};
        end else if (hit(paddr, ocf_pkg::IDX_PORT)) begin
            rd_val = {24'h000000, port_reg};
        end else begin
            known  = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare events and pin actions

    logic       ch7_event;
    logic [7:0] ch7_route;
    logic [7:0] fire;
    logic [7:0] act_pin;
    logic [7:0] tgt;

    // Channel 7 event: its own match, or overflow with the toggle select set
    always_comb begin
        ch7_event = (compare_match[ocf_pkg::CH7] && channel_mode_select_reg[ocf_pkg::CH7])
                    || (counter_overflow && overflow_toggle_select_reg[ocf_pkg::CH7]);
        // Only mask bits of output compare channels that are still connected
        ch7_route = ch7_compare_mask_reg & channel_mode_select_reg
                    & ~output_disconnect_reg;
        fire      = (compare_match | force_bit_reg) & channel_mode_select_reg;
    end

    genvar g;
    generate
        for (g = 0; g < ocf_pkg::NUM_CH; g++) begin : g_ch
            ocf_pin_action u_act (
                .action (action_reg[2*g+1:2*g]),
                .cur    (port_reg[g]),
                .fire   (fire[g]),
                .nxt    (act_pin[g])
            );
        end
    endgenerate

    // Routed pins take the data bit; other low channels hold on a channel 7 event
    always_comb begin
        tgt = act_pin;
        for (int i = 0; i < ocf_pkg::NUM_CH; i++) begin
            if (ch7_event && ch7_route[i]) begin
                tgt[i] = ch7_compare_data_reg[i];
            end else if (ch7_event && i != ocf_pkg::CH7) begin
                tgt[i] = port_reg[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channel 7 override registers

    always_comb begin
        ch7_compare_mask_next = ch7_compare_mask_reg;
        ch7_compare_data_next = ch7_compare_data_reg;
        if (wr && hit(paddr, ocf_pkg::IDX_MASK)) begin
            ch7_compare_mask_next = pwdata[7:0];
        end else if (wr && hit(paddr, ocf_pkg::IDX_DATA)) begin
            ch7_compare_data_next = pwdata[7:0];
        end
    end

    // The data register has no defined start value; it starts cleared
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch7_compare_mask_reg <= ocf_pkg::RST_MASK;
            ch7_compare_data_reg <= ocf_pkg::RST_DATA;
        end else begin
            ch7_compare_mask_reg <= ch7_compare_mask_next;
            ch7_compare_data_reg <= ch7_compare_data_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channel setup registers

    always_comb begin
        channel_mode_select_next    = channel_mode_select_reg;
        output_disconnect_next      = output_disconnect_reg;
        overflow_toggle_select_next = overflow_toggle_select_reg;
        action_next                 = action_reg;
        if (wr) begin
            if (hit(paddr, ocf_pkg::IDX_MODE)) begin
                channel_mode_select_next = pwdata[7:0];
            end else if (hit(paddr, ocf_pkg::IDX_DISC)) begin
                output_disconnect_next = pwdata[7:0];
            end else if (hit(paddr, ocf_pkg::IDX_TOVSEL)) begin
                overflow_toggle_select_next = pwdata[7:0];
            end else if (hit(paddr, ocf_pkg::IDX_ACTION_LO)) begin
                action_next[7:0] = pwdata[7:0];
            end else if (hit(paddr, ocf_pkg::IDX_ACTION_HI)) begin
                action_next[15:8] = pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_mode_select_reg    <= ocf_pkg::RST_REG8;
            output_disconnect_reg      <= ocf_pkg::RST_REG8;
            overflow_toggle_select_reg <= ocf_pkg::RST_REG8;
            action_reg                 <= ocf_pkg::RST_ACTION;
        end else begin
            channel_mode_select_reg    <= channel_mode_select_next;
            output_disconnect_reg      <= output_disconnect_next;
            overflow_toggle_select_reg <= overflow_toggle_select_next;
            action_reg                 <= action_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Force pulse

    // Lives for one cycle only, so a later read has nothing to return
    always_comb begin
        force_bit_next = 8'h00;
        if (wr && hit(paddr, ocf_pkg::IDX_FORCE)) begin
            force_bit_next = pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            force_bit_reg <= ocf_pkg::RST_REG8;
        end else begin
            force_bit_reg <= force_bit_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare flags

    always_comb begin
        flag_next = flag_reg;
        if (wr && hit(paddr, ocf_pkg::IDX_FLAGS)) begin
            flag_next = flag_reg & ~pwdata[7:0];
        end
        // Match sets the flag unless forced in the same cycle; set beats clear
        flag_next = flag_next
                    | (compare_match & channel_mode_select_reg & ~force_bit_reg);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= ocf_pkg::RST_REG8;
        end else begin
            flag_reg <= flag_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timer port data

    // Follows the pin actions every cycle; software only reads it
    always_comb begin
        port_next = tgt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_reg <= ocf_pkg::RST_REG8;
        end else begin
            port_reg <= port_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus response

    // Read data holds until the next read; the error marks unmapped words and byte offsets inside a word
    always_comb begin
        pready_next  = access;
        pslverr_next = access && !known;
        prdata_next  = prdata_reg;
        if (access && !pwrite) begin
            prdata_next = rd_val;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= ocf_pkg::UNMAPPED_READ;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    logic [7:0] oe_reg, oe_next;

    always_comb begin
        oe_next = channel_mode_select_next & ~output_disconnect_next;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oe_reg <= ocf_pkg::RST_REG8;
        end else begin
            oe_reg <= oe_next;
        end
    end

    assign prdata       = prdata_reg;
    assign pready       = pready_reg;
    assign pslverr      = pslverr_reg;
    assign pin_out      = port_reg;
    assign pin_oe       = oe_reg;
    assign compare_flag = flag_reg;

endmodule

/* File: ocf_compare_force_props.sv */
// Checker: bus timing and flag properties of the compare force block
`timescale 1ns/1ps
module ocf_props #(
    parameter int ADDR_W = 12
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [7:0]        compare_match,
    input wire logic [7:0]        pin_out,
    input wire logic [7:0]        compare_flag
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_wait; psel && penable && !pready; endsequence
    sequence s_rd_force;
        psel && penable && !pwrite && pready && paddr == ADDR_W'({ocf_pkg::IDX_FORCE, 2'b00});
    endsequence
    property p_ready_wait; s_wait |=> pready; endproperty
    property p_ready_pulse; pready |=> !pready; endproperty
    property p_err_ready; pslverr |-> pready; endproperty
    property p_force_zero; s_rd_force |-> prdata == 32'h00000000; endproperty
    property p_err_read; pslverr && !pwrite |-> prdata == 32'h00000000; endproperty
    property p_upper_zero; pready && !pwrite |-> prdata[31:8] == 24'h000000; endproperty
    property p_flag_cause;
        ((compare_flag & ~$past(compare_flag)) & ~$past(compare_match)) == 8'h00;
    endproperty
    property p_reset_quiet;
        $rose(presetn) |-> pin_out == 8'h00 && compare_flag == 8'h00 && !pready;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("no answer after access");
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than a cycle");
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    a_force_zero: assert property (p_force_zero) else $error("force reads nonzero");
    a_err_read: assert property (p_err_read) else $error("unmapped read nonzero");
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
    a_flag_cause: assert property (p_flag_cause) else $error("flag without match");
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
endmodule
bind ocf_compare_force ocf_props #(.ADDR_W(ADDR_W)) u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .compare_match(compare_match), .pin_out(pin_out),
    .compare_flag(compare_flag));

/* File: tb.sv */
// Testbench: register, force and channel 7 event scenarios
`timescale 1ns/1ps
module tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [7:0]  cm = 8'h00;
    logic        ovf = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  pin_out;
    logic [7:0]  pin_oe;
    logic [7:0]  flag;
    int          num_errors = 0;
    int          compares = 0;
    ocf_compare_force #(.ADDR_W(12)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .compare_match(cm),
        .counter_overflow(ovf), .pin_out(pin_out), .pin_oe(pin_oe), .compare_flag(flag));
    always #10 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        compares++;
        if (g !== x) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, x, g);
        end
    endtask
    // One APB transfer; m drives compare matches in the cycle the force pulse lives
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       input logic [7:0] m, output logic [31:0] rd, output logic er);
        int n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {2'h0, idx, 2'h0};
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        cm      <= m;
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n == 50) num_errors++;
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        cm      <= 8'h00;
        @(negedge pclk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, idx, d, 8'h00, r, e);
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, idx, 8'h00, 8'h00, r, e);
        chk("read", x, r);
    endtask
    task automatic pulse(input logic o, input logic [7:0] m);
        @(posedge pclk);
        ovf <= o;
        cm  <= m;
        @(posedge pclk);
        ovf <= 1'b0;
        cm  <= 8'h00;
        @(posedge pclk);
        @(negedge pclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [31:0] r;
        logic        e;
        rdc(ocf_pkg::IDX_MASK, 32'h00000000);
        rdc(ocf_pkg::IDX_DATA, 32'h00000000);
        wr(ocf_pkg::IDX_MASK, 8'hA5);
        rdc(ocf_pkg::IDX_MASK, 32'h000000A5);
        wr(ocf_pkg::IDX_ACTION_LO, 8'hFF);
        wr(ocf_pkg::IDX_FORCE, 8'hFF);
        chk("capture pin", 32'h00000000, {24'h0, pin_out});
        rdc(ocf_pkg::IDX_FORCE, 32'h00000000);
        apb(1'b0, 8'h3F, 8'h00, 8'h00, r, e);
        chk("unmapped error", 32'h00000001, {31'h0, e});
        $display("test regs done");
    endtask
    task automatic t_force();
        wr(ocf_pkg::IDX_MODE, 8'hFF);
        wr(ocf_pkg::IDX_DISC, 8'h00);
        chk("pin_oe", 32'h000000FF, {24'h0, pin_oe});
        wr(ocf_pkg::IDX_ACTION_LO, 8'hFF);
        wr(ocf_pkg::IDX_ACTION_HI, 8'hFF);
        wr(ocf_pkg::IDX_FORCE, 8'h0F);
        chk("pin set", 32'h0000000F, {24'h0, pin_out});
        chk("flag", 32'h00000000, {24'h0, flag});
        wr(ocf_pkg::IDX_ACTION_LO, 8'hAA);
        wr(ocf_pkg::IDX_FORCE, 8'h03);
        chk("pin clear", 32'h0000000C, {24'h0, pin_out});
        wr(ocf_pkg::IDX_ACTION_HI, 8'h55);
        wr(ocf_pkg::IDX_FORCE, 8'hF0);
        chk("pin toggle", 32'h000000FC, {24'h0, pin_out});
        wr(ocf_pkg::IDX_ACTION_LO, 8'h00);
        wr(ocf_pkg::IDX_FORCE, 8'h0C);
        chk("pin none", 32'h000000FC, {24'h0, pin_out});
        $display("test force done");
    endtask
    task automatic t_race();
        logic [31:0] r;
        logic        e;
        wr(ocf_pkg::IDX_ACTION_LO, 8'h03);
        apb(1'b1, ocf_pkg::IDX_FORCE, 8'h01, 8'h01, r, e);
        chk("race pin", 32'h000000FD, {24'h0, pin_out});
        chk("race flag", 32'h00000000, {24'h0, flag});
        $display("test race done");
    endtask
    task automatic t_ch7();
        wr(ocf_pkg::IDX_TOVSEL, 8'h80);
        wr(ocf_pkg::IDX_MASK, 8'h0F);
        wr(ocf_pkg::IDX_DATA, 8'h0A);
        wr(ocf_pkg::IDX_ACTION_HI, 8'h01);
        pulse(1'b1, 8'h10);
        chk("overflow event", 32'h000000FA, {24'h0, pin_out});
        wr(ocf_pkg::IDX_DATA, 8'h05);
        pulse(1'b0, 8'h80);
        chk("match event", 32'h000000F5, {24'h0, pin_out});
        chk("flag7", 32'h00000001, {31'h0, flag[7]});
        wr(ocf_pkg::IDX_DISC, 8'h01);
        chk("pin_oe disc", 32'h000000FE, {24'h0, pin_oe});
        wr(ocf_pkg::IDX_DATA, 8'h0A);
        pulse(1'b0, 8'h80);
        chk("disc event", 32'h000000FB, {24'h0, pin_out});
        $display("test ch7 done");
    endtask
    task automatic report_and_stop();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        num_errors++;
        report_and_stop();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_force();
        t_race();
        t_ch7();
        report_and_stop();
    end
endmodule
